// ==== design/tdc_top.sv ====
// Register access over APB was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tdc_defines.svh"
module tdc_top
   import tdc_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int CNT_W = 10
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic instr_tick,
   input wire logic hosc_tick,
   input wire logic ext_clock_pin,
   output logic [2:0] pwm_pin_out,
   output logic [2:0] pwm_pin_sel,
   output logic tog_pin_out,
   output logic tog_pin_sel,
   output logic high_osc_clock_force
);
   tdc_presc_if pif ();

   logic [7:0] mode_reg, mode_next;
   logic [7:0] clk_reg, clk_next;
   logic [7:0] high_reg, high_next;
   logic [7:0] duty_reg, duty_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [CNT_W-1:0] count_reg, count_next;
   logic [CNT_W-1:0] reload_reg, reload_next;
   tdc_cnt_state_t st_reg, st_next;
   logic tog_reg, tog_next;
   logic pwm_lvl_reg, pwm_lvl_next;
   logic ext_s1_reg, ext_s2_reg, ext_s3_reg, ext_stable_reg, ext_stable_next;
   logic ext_rise, ext_fall, ext_event;
   logic setup, access, hit, wr_count, underflow, pwm_active;
   logic [5:0] idx;
   logic [CNT_W-1:0] duty_full;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   assign idx = paddr[7:2];
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign hit = (paddr[1:0] == 2'b00) && (idx == `TDC_IDX_COUNT || idx == `TDC_IDX_MODE || idx == `TDC_IDX_CLOCK
      || idx == `TDC_IDX_HIGH || idx == `TDC_IDX_DUTY || idx == `TDC_IDX_CNTHI);
   assign pready = 1'b1;
   assign pslverr = access && !hit;
   assign prdata = rdata_reg;
   assign wr_count = access && pwrite && hit && idx == `TDC_IDX_COUNT;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_comb
   begin
      mode_next = mode_reg;
      clk_next = clk_reg;
      high_next = high_reg;
      duty_next = duty_reg;
      rdata_next = rdata_reg;
      if (access && pwrite && hit)
      begin
         case (idx)
            `TDC_IDX_MODE: mode_next = pwdata[7:0] & `TDC_MODE_WMASK;
            `TDC_IDX_CLOCK: clk_next = pwdata[7:0] & `TDC_CLK_WMASK;
            `TDC_IDX_HIGH: high_next = pwdata[7:0] & `TDC_HIGH_WMASK;
            `TDC_IDX_DUTY: duty_next = pwdata[7:0];
            default: mode_next = mode_reg;
         endcase
      end
      if (setup && !pwrite)
      begin
         case (idx)
            `TDC_IDX_COUNT: rdata_next = {24'h000000, count_reg[7:0]};
            `TDC_IDX_MODE: rdata_next = {24'h000000, mode_reg};
            `TDC_IDX_CLOCK: rdata_next = {24'h000000, clk_reg};
            `TDC_IDX_HIGH: rdata_next = {24'h000000, high_reg};
            `TDC_IDX_DUTY: rdata_next = {24'h000000, duty_reg};
            `TDC_IDX_CNTHI: rdata_next = {30'h0, count_reg[9:8]};
            default: rdata_next = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_reg <= `TDC_MODE_RESET;
         clk_reg <= `TDC_CLK_RESET;
         high_reg <= `TDC_HIGH_RESET;
         duty_reg <= `TDC_DUTY_RESET;
         rdata_reg <= 32'h00000000;
      end
      else
      begin
         mode_reg <= mode_next;
         clk_reg <= clk_next;
         high_reg <= high_next;
         duty_reg <= duty_next;
         rdata_reg <= rdata_next;
      end
   end

   // ----------------------------------------
   // external clock pin sync and edge
   // ----------------------------------------
   always_comb
   begin
      ext_stable_next = ext_stable_reg;
      if (ext_s2_reg == ext_s3_reg)
      begin
         ext_stable_next = ext_s3_reg;
      end
   end

   assign ext_rise = (ext_s2_reg == ext_s3_reg) && ext_s3_reg && !ext_stable_reg;
   assign ext_fall = (ext_s2_reg == ext_s3_reg) && !ext_s3_reg && ext_stable_reg;
   assign ext_event = mode_reg[`TDC_MODE_HOSC] ? 1'b0 : (clk_reg[`TDC_CLK_EDGE] ? ext_fall : ext_rise);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_s1_reg <= 1'b0;
         ext_s2_reg <= 1'b0;
         ext_s3_reg <= 1'b0;
         ext_stable_reg <= 1'b0;
      end
      else
      begin
         ext_s1_reg <= ext_clock_pin;
         ext_s2_reg <= ext_s1_reg;
         ext_s3_reg <= ext_s2_reg;
         ext_stable_reg <= ext_stable_next;
      end
   end

   // ----------------------------------------
   // clock source and prescaler
   // ----------------------------------------
   always_comb
   begin
      if (mode_reg[`TDC_MODE_HOSC])
      begin
         pif.src_tick = hosc_tick;
      end
      else if (clk_reg[`TDC_CLK_EXT_SEL])
      begin
         pif.src_tick = ext_event;
      end
      else
      begin
         pif.src_tick = instr_tick;
      end
   end

   // software changes the ratio only while bypassed, which clears the prescaler; no hardware interlock
   assign pif.bypass = clk_reg[`TDC_CLK_PS_DIS_N];
   assign pif.sel = clk_reg[`TDC_CLK_SEL_HI:`TDC_CLK_SEL_LO];
   assign high_osc_clock_force = mode_reg[`TDC_MODE_HOSC];

   tdc_prescaler #(.CNT_W(8)) u_psc (
      .pclk(pclk),
      .presetn(presetn),
      .pif(pif)
   );

   // ----------------------------------------
   // down counter
   // ----------------------------------------
   always_comb
   begin
      count_next = count_reg;
      reload_next = reload_reg;
      st_next = st_reg;
      tog_next = tog_reg;
      underflow = 1'b0;
      if (wr_count)
      begin
         count_next = {high_reg[7:6], pwdata[7:0]};
         reload_next = {high_reg[7:6], pwdata[7:0]};
         st_next = CS_RUN;
      end
      else if (st_reg == CS_DONE && !mode_reg[`TDC_MODE_ONESHOT])
      begin
         st_next = CS_RUN;
      end
      else if (mode_reg[`TDC_MODE_EN] && pif.div_tick && st_reg == CS_RUN)
      begin
         if (count_reg == '0)
         begin
            if (mode_reg[`TDC_MODE_ONESHOT])
            begin
               st_next = CS_DONE;
            end
            else
            begin
               underflow = 1'b1;
               tog_next = !tog_reg;
               count_next = mode_reg[`TDC_MODE_RELOAD] ? reload_reg : `TDC_FULL_SCALE;
            end
         end
         else
         begin
            count_next = count_reg - CNT_W'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count_reg <= `TDC_COUNT_RESET;
         reload_reg <= `TDC_COUNT_RESET;
         st_reg <= CS_RUN;
         tog_reg <= 1'b0;
      end
      else
      begin
         count_reg <= count_next;
         reload_reg <= reload_next;
         st_reg <= st_next;
         tog_reg <= tog_next;
      end
   end

   // ----------------------------------------
   // pwm and pins
   // ----------------------------------------
   assign duty_full = {high_reg[3:2], duty_reg};
   assign pwm_active = count_reg < duty_full;
   assign pwm_lvl_next = pwm_active ^ mode_reg[`TDC_MODE_PWM_AL];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pwm_lvl_reg <= 1'b0;
      end
      else
      begin
         pwm_lvl_reg <= pwm_lvl_next;
      end
   end

   assign pwm_pin_out = {3{pwm_lvl_reg}};
   assign pwm_pin_sel = {3{mode_reg[`TDC_MODE_PWM_EN]}};
   assign tog_pin_out = tog_reg;
   assign tog_pin_sel = mode_reg[`TDC_MODE_TOG_OE];

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_read_count: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && idx == `TDC_IDX_COUNT) |=> (prdata[7:0] == $past(count_reg[7:0])))
      else $error("count read does not return live count");
   a_write_loads: assert property (@(posedge pclk) disable iff (!presetn)
      wr_count |=> (count_reg == {$past(high_reg[7:6]), $past(pwdata[7:0])} && reload_reg == count_reg))
      else $error("count write did not load both");
   a_hold_disabled: assert property (@(posedge pclk) disable iff (!presetn)
      (!mode_reg[`TDC_MODE_EN] && !wr_count) |=> $stable(count_reg))
      else $error("counter moved while disabled");
   a_reload_used: assert property (@(posedge pclk) disable iff (!presetn)
      (underflow && mode_reg[`TDC_MODE_RELOAD]) |=> (count_reg == $past(reload_reg)))
      else $error("reload value not taken on underflow");
   a_full_scale: assert property (@(posedge pclk) disable iff (!presetn)
      (underflow && !mode_reg[`TDC_MODE_RELOAD]) |=> (count_reg == 10'h3FF))
      else $error("full scale not loaded on underflow");
   a_oneshot_stop: assert property (@(posedge pclk) disable iff (!presetn)
      (st_reg == CS_DONE && mode_reg[`TDC_MODE_ONESHOT] && !wr_count) |=> (count_reg == '0 && st_reg == CS_DONE))
      else $error("one-shot did not stop at zero");
   a_freerun_wrap: assert property (@(posedge pclk) disable iff (!presetn)
      (mode_reg[`TDC_MODE_EN] && pif.div_tick && count_reg == '0 && !mode_reg[`TDC_MODE_ONESHOT]
      && st_reg == CS_RUN && !wr_count) |-> underflow)
      else $error("free-run did not wrap");
   a_pwm_polarity: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> (pwm_pin_out[0] == ($past(count_reg < duty_full) ^ $past(mode_reg[`TDC_MODE_PWM_AL]))))
      else $error("pwm polarity wrong");
   a_toggle_flip: assert property (@(posedge pclk) disable iff (!presetn)
      underflow |=> (tog_pin_out != $past(tog_pin_out)))
      else $error("toggle did not flip on underflow");
   a_hosc_force: assert property (@(posedge pclk) disable iff (!presetn)
      mode_reg[`TDC_MODE_HOSC] |-> (pif.src_tick == hosc_tick))
      else $error("high oscillator not forced");
   a_ext_edge: assert property (@(posedge pclk) disable iff (!presetn)
      (!mode_reg[`TDC_MODE_HOSC] && clk_reg[`TDC_CLK_EXT_SEL] && !clk_reg[`TDC_CLK_EDGE] && ext_rise)
      |-> pif.src_tick)
      else $error("rising external edge not counted");
endmodule : tdc_top
`default_nettype wire

// ==== design/tdc_defines.svh ====
`ifndef TDC_DEFINES_SVH
`define TDC_DEFINES_SVH

// ----------------------------------------
// register indices, byte address = index * 4
// ----------------------------------------
`define TDC_IDX_COUNT 6'h09
`define TDC_IDX_MODE 6'h0A
`define TDC_IDX_CLOCK 6'h0B
`define TDC_IDX_HIGH 6'h10
`define TDC_IDX_DUTY 6'h11
`define TDC_IDX_CNTHI 6'h12

// ----------------------------------------
// mode control fields
// ----------------------------------------
`define TDC_MODE_PWM_EN 7
`define TDC_MODE_PWM_AL 6
`define TDC_MODE_TOG_OE 5
`define TDC_MODE_HOSC 3
`define TDC_MODE_ONESHOT 2
`define TDC_MODE_RELOAD 1
`define TDC_MODE_EN 0
`define TDC_MODE_WMASK 8'hEF
`define TDC_MODE_RESET 8'h00

// ----------------------------------------
// clock control fields
// ----------------------------------------
`define TDC_CLK_EXT_SEL 5
`define TDC_CLK_EDGE 4
`define TDC_CLK_PS_DIS_N 3
`define TDC_CLK_SEL_HI 2
`define TDC_CLK_SEL_LO 0
`define TDC_CLK_WMASK 8'h3F
`define TDC_CLK_RESET 8'h3F

// ----------------------------------------
// shared high bits, reload at 7:6, duty at 3:2
// ----------------------------------------
`define TDC_HIGH_WMASK 8'hCC
`define TDC_HIGH_RESET 8'h00
`define TDC_DUTY_RESET 8'h00
`define TDC_FULL_SCALE 10'h3FF
`define TDC_COUNT_RESET 10'h3FF

`endif

// ==== design/tdc_pkg.sv ====
`default_nettype none
package tdc_pkg;
   typedef enum logic [0:0] {
      CS_RUN = 1'b0,
      CS_DONE = 1'b1
   } tdc_cnt_state_t;
endpackage : tdc_pkg
`default_nettype wire

// ==== design/tdc_presc_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface tdc_presc_if;
   logic src_tick;
   logic bypass;
   logic [2:0] sel;
   logic div_tick;
   modport ctl (output src_tick, output bypass, output sel, input div_tick);
   modport psc (input src_tick, input bypass, input sel, output div_tick);
endinterface : tdc_presc_if
`default_nettype wire

// ==== design/tdc_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
module tdc_prescaler
   import tdc_pkg::*;
#(
   parameter int CNT_W = 8
)
(
   input wire logic pclk,
   input wire logic presetn,
   tdc_presc_if.psc pif
);
   logic [CNT_W-1:0] psc_reg;
   logic [CNT_W-1:0] psc_next;
   logic [CNT_W-1:0] psc_mask;

   // ----------------------------------------
   // divider
   // ----------------------------------------
   always_comb
   begin
      psc_mask = CNT_W'((9'h002 << pif.sel) - 9'h001);
      psc_next = psc_reg;
      if (pif.bypass)
      begin
         psc_next = '0;
      end
      else if (pif.src_tick)
      begin
         psc_next = psc_reg + CNT_W'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         psc_reg <= '0;
      end
      else
      begin
         psc_reg <= psc_next;
      end
   end

   assign pif.div_tick = pif.bypass ? pif.src_tick : (pif.src_tick && ((psc_reg & psc_mask) == psc_mask));

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_bypass_passes: assert property (@(posedge pclk) disable iff (!presetn) pif.bypass |-> (pif.div_tick == pif.src_tick)) else $error("bypass does not pass source tick");
   a_full_fires: assert property (@(posedge pclk) disable iff (!presetn) (!pif.bypass && pif.src_tick && psc_reg == {CNT_W{1'b1}}) |-> pif.div_tick) else $error("prescaler missed terminal count");
   a_even_quiet: assert property (@(posedge pclk) disable iff (!presetn) (!pif.bypass && !psc_reg[0]) |-> !pif.div_tick) else $error("prescaler fired on even count");
endmodule : tdc_prescaler
`default_nettype wire

// ==== verif/tdc_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// external clock pin source
// ----------------------------------------
module tdc_pin_model
(
   input wire logic pclk,
   output logic ext_clock_pin
);
   initial ext_clock_pin = 1'b0;
   // full pulses, each level held past the pin synchroniser
   task automatic edges(input int n);
      repeat (n)
      begin
         @(posedge pclk) ext_clock_pin <= 1'b1;
         repeat (8) @(posedge pclk);
         ext_clock_pin <= 1'b0;
         repeat (8) @(posedge pclk);
      end
   endtask : edges
endmodule : tdc_pin_model
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tdc_defines.svh"
module tb_top;
   import tdc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic instr_tick = 0, hosc_tick = 0, ext_clock_pin, tog_pin_out, tog_pin_sel, high_osc_clock_force;
   logic [2:0] pwm_pin_out, pwm_pin_sel;
   logic [9:0] exp_q[$];
   logic [9:0] e;
   logic [7:0] v;
   int n_mismatch = 0, total_checks = 0, cyc = 0;
   int seed = 32'h3b19;
   always #5 pclk = ~pclk;
   tdc_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .instr_tick(instr_tick), .hosc_tick(hosc_tick), .ext_clock_pin(ext_clock_pin),
      .pwm_pin_out(pwm_pin_out), .pwm_pin_sel(pwm_pin_sel), .tog_pin_out(tog_pin_out),
      .tog_pin_sel(tog_pin_sel), .high_osc_clock_force(high_osc_clock_force));
   tdc_pin_model u_pin (.pclk(pclk), .ext_clock_pin(ext_clock_pin));
   // ----------------------------------------
   // checking and closing
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
      total_checks++;
      if (s !== ex)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, s);
      end
   endtask : chk
   // pin level compare, expected first
   task automatic chk_pin(input string nm, input logic [31:0] ex, input logic [31:0] s);
      chk(nm, ex, s);
   endtask : chk_pin
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_mismatch++;
         stop_test();
      end
   end
   // monitor: each completed transfer takes the oldest note
   always @(posedge pclk)
   begin
      if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
      begin
         e = exp_q.pop_front();
         chk("pslverr", {31'h0, e[8]}, {31'h0, pslverr});
         if (!e[9])
            chk("prdata", {24'h0, e[7:0]}, prdata);
      end
   end
   // ----------------------------------------
   // stimulus tasks
   // ----------------------------------------
   task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d, input logic [7:0] ex,
      input logic err);
      exp_q.push_back({w, err, ex});
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      paddr <= {idx, 2'b00};
      pwrite <= w;
      pwdata <= {24'h0, d};
      @(posedge pclk) penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic ticks(input int n, input logic h);
      repeat (n)
      begin
         @(posedge pclk);
         instr_tick <= !h;
         hosc_tick <= h;
         @(posedge pclk);
         instr_tick <= 0;
         hosc_tick <= 0;
      end
   endtask : ticks
   task automatic setc(input logic [7:0] c);
      apb(1, `TDC_IDX_COUNT, c, 0, 0);
   endtask : setc
   task automatic rdc(input logic [7:0] c);
      apb(0, `TDC_IDX_COUNT, 0, c, 0);
   endtask : rdc
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      apb(0, `TDC_IDX_MODE, 0, 8'h00, 0);
      apb(0, `TDC_IDX_CLOCK, 0, 8'h3F, 0);
      rdc(8'hFF);
      apb(0, `TDC_IDX_CNTHI, 0, 8'h03, 0);
      apb(0, 6'h3F, 0, 8'h00, 1);
      apb(1, 6'h3F, 8'h55, 0, 1);
      apb(1, `TDC_IDX_MODE, 8'hFE, 0, 0);
      apb(0, `TDC_IDX_MODE, 0, 8'hEE, 0);
      apb(1, `TDC_IDX_MODE, 8'h00, 0, 0);
      v = 8'($random(seed));
      apb(1, `TDC_IDX_HIGH, 8'h40, 0, 0);
      setc(v);
      rdc(v);
      apb(0, `TDC_IDX_CNTHI, 0, 8'h01, 0);
      apb(1, `TDC_IDX_CLOCK, 8'h08, 0, 0);
      ticks(5, 0);
      rdc(v);
      apb(1, `TDC_IDX_HIGH, 8'h00, 0, 0);
      setc(8'h03);
      apb(1, `TDC_IDX_MODE, 8'h23, 0, 0);
      ticks(3, 0);
      rdc(8'h00);
      ticks(1, 0);
      rdc(8'h03);
      chk_pin("tog", 32'h3, {30'h0, tog_pin_sel, tog_pin_out});
      apb(1, `TDC_IDX_MODE, 8'h21, 0, 0);
      ticks(4, 0);
      rdc(8'hFF);
      apb(0, `TDC_IDX_CNTHI, 0, 8'h03, 0);
      chk_pin("tog", 32'h0, {31'h0, tog_pin_out});
      setc(8'h02);
      apb(1, `TDC_IDX_MODE, 8'h27, 0, 0);
      ticks(5, 0);
      rdc(8'h00);
      chk_pin("tog", 32'h0, {31'h0, tog_pin_out});
      apb(1, `TDC_IDX_MODE, 8'h09, 0, 0);
      setc(8'h10);
      ticks(3, 0);
      rdc(8'h10);
      ticks(3, 1);
      rdc(8'h0D);
      chk_pin("force", 32'h1, {31'h0, high_osc_clock_force});
      apb(1, `TDC_IDX_MODE, 8'h01, 0, 0);
      for (int s = 0; s < 8; s++)
      begin
         apb(1, `TDC_IDX_CLOCK, 8'h08 | s[7:0], 0, 0);
         setc(8'h10);
         apb(1, `TDC_IDX_CLOCK, s[7:0], 0, 0);
         ticks((2 << s) * 2, 0);
         rdc(8'h0E);
      end
      apb(1, `TDC_IDX_CLOCK, 8'h28, 0, 0);
      setc(8'h10);
      u_pin.edges(3);
      rdc(8'h0D);
      apb(1, `TDC_IDX_CLOCK, 8'h38, 0, 0);
      u_pin.edges(2);
      rdc(8'h0B);
      apb(1, `TDC_IDX_MODE, 8'h80, 0, 0);
      setc(8'h10);
      apb(1, `TDC_IDX_DUTY, 8'h20, 0, 0);
      repeat (3) @(posedge pclk);
      chk_pin("pwm", 32'h3F, {26'h0, pwm_pin_sel, pwm_pin_out});
      apb(1, `TDC_IDX_MODE, 8'hC0, 0, 0);
      repeat (3) @(posedge pclk);
      chk_pin("pwm", 32'h0, {29'h0, pwm_pin_out});
      v = 8'($random(seed)) & 8'h0F;
      apb(1, `TDC_IDX_DUTY, v, 0, 0);
      repeat (3) @(posedge pclk);
      chk_pin("pwm", 32'h7, {29'h0, pwm_pin_out});
      apb(1, `TDC_IDX_MODE, 8'h00, 0, 0);
      repeat (3) @(posedge pclk);
      chk_pin("pwm_sel", 32'h0, {29'h0, pwm_pin_sel});
      chk_pin("tog_sel", 32'h0, {31'h0, tog_pin_sel});
      repeat (3) @(posedge pclk);
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
